// *** core/adcsq_pkg.sv ***
// Function
// R1: Enabled trigger pin edge sets the start bit.
// R2: Trigger edge polarity comes from a separate edge select bit.
// R3: Trigger control bits 6 to 1 always read back as 1.
// R4: Software never writes 1 to trigger control bit 0; it resets to 0.
// R5: Ten-bit successive approximation with single and scan modes only.
// R6: Software clears the start bit before changing mode or channel.
// R7: One write may set start with new mode and channel.
// R8: Single mode converts the selected channel once into its data register.
// R9: Single completion sets end flag; interrupt if enabled.
// R10: Single mode start bit reads 1 while busy, then clears itself.
// R11: Scan starts at channel 0 or 4 by group bit, four channels at most.
// R12: Scan stores each result in its channel register, in order.
// R13: Full scan round sets end flag, restarts at first channel.
// R14: Scan start bit never self-clears; rounds repeat until cleared.
// R15: After start wait a delay, sample, then run the approximation.
// R16: Start delay 6 to 9 states at speed 0, 4 to 5 at speed 1.
// R17: Single conversion totals 131 to 134 or 69 to 70 states.
// R18: Later scan conversions take fixed 128 or 66 states.
// R19: Triggered start acts like a software start.
// R20: End flag clears only by writing 0 after reading it as 1.
// R21: Reset or standby clears start bit, stopping conversion.
// R22: Interrupt request is end flag AND enable.
package adcsq_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADCSQ_CSR_OFS   = 8'h00;
  localparam logic [7:0] ADCSQ_TRG_OFS   = 8'h04;
  localparam logic [7:0] ADCSQ_EDGE_OFS  = 8'h08;
  localparam logic [7:0] ADCSQ_DATA_OFS  = 8'h20;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int ADCSQ_ADF_BIT   = 7;
  localparam int ADCSQ_CONV_END_IRQ_ENABLE_BIT  = 6;
  localparam int ADCSQ_CONV_START_BIT_BIT  = 5;
  localparam int ADCSQ_SCAN_BIT  = 4;
  localparam int ADCSQ_CKS_BIT   = 3;
  localparam int ADCSQ_EXT_TRIGGER_ENABLE_BIT  = 7;
  localparam logic [5:0] ADCSQ_TRG_RSVD = 6'h3F;
  localparam logic [7:0] ADCSQ_CSR_RST  = 8'h00;

  // ---------------------------------------------------------------
  // Timing in states (one state is one sys_clk_i cycle)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADCSQ_DLY0_MIN  = 8'h06;
  localparam logic [7:0] ADCSQ_DLY1_MIN  = 8'h04;
  localparam logic [7:0] ADCSQ_DLY0_FIX  = 8'h03;
  localparam logic [7:0] ADCSQ_DLY1_FIX  = 8'h01;
  localparam logic [7:0] ADCSQ_SPL0      = 8'h1F;
  localparam logic [7:0] ADCSQ_SPL1      = 8'h0F;
  localparam logic [7:0] ADCSQ_CNV0      = 8'h5E;
  localparam logic [7:0] ADCSQ_CNV1      = 8'h32;
  localparam logic [7:0] ADCSQ_STEP0     = 8'h09;
  localparam logic [7:0] ADCSQ_STEP1     = 8'h05;
  localparam int         ADCSQ_RES_W     = 10;

  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_DELAY, ADCSQ_SAMPLE, ADCSQ_CONV} adcsq_state_t;

endpackage

// *** core/adcsq_edge.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsq_edge
  import adcsq_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  // Trigger
  input  wire logic pin_i,
  input  wire logic enable_i,
  input  wire logic rising_i,
  output logic      fire_o
);

  logic pin_r;

  wire rise_w = pin_i & ~pin_r;
  wire fall_w = ~pin_i & pin_r;
  wire hit_w  = enable_i & (rising_i ? rise_w : fall_w); // R1 R2

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_r  <= 1'b1;
      fire_o <= 1'b0;
    end
    else
    begin
      pin_r  <= pin_i;
      fire_o <= hit_w;
    end
  end

endmodule
`default_nettype wire

// *** core/adcsq_conv.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsq_conv
  import adcsq_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  // Control
  input  wire logic                   start_i,
  input  wire logic                   abort_i,
  input  wire logic                   first_i,
  input  wire logic                   cks_i,
  input  wire logic [1:0]             phase_i,
  // Analog side
  input  wire logic                   cmp_i,
  output logic                        sample_o,
  output logic [ADCSQ_RES_W-1:0]      dac_o,
  // Result
  output logic                        done_o,
  output logic [ADCSQ_RES_W-1:0]      result_o
);

  adcsq_state_t st_r;
  logic [7:0]   cnt_r;
  logic [7:0]   stp_r;
  logic [3:0]   idx_r;

  wire [7:0] dly_w = first_i ? (cks_i ? ADCSQ_DLY1_MIN + {7'h00, phase_i[0]}
                                      : ADCSQ_DLY0_MIN + {6'h00, phase_i})
                             : (cks_i ? ADCSQ_DLY1_FIX : ADCSQ_DLY0_FIX); // R16 R18
  wire [7:0] spl_w  = cks_i ? ADCSQ_SPL1 : ADCSQ_SPL0;
  wire [7:0] cnv_w  = cks_i ? ADCSQ_CNV1 : ADCSQ_CNV0; // R17
  wire [7:0] step_w = cks_i ? ADCSQ_STEP1 : ADCSQ_STEP0;
  wire       last_w = (cnt_r == 8'h00);
  wire       bit_w  = (stp_r == 8'h00) && (idx_r != 4'hF);

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_r     <= ADCSQ_IDLE;
      cnt_r    <= 8'h00;
      stp_r    <= 8'h00;
      idx_r    <= 4'h0;
      sample_o <= 1'b0;
      dac_o    <= '0;
      done_o   <= 1'b0;
      result_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (abort_i)
      begin
        st_r     <= ADCSQ_IDLE;
        sample_o <= 1'b0;
      end
      else
      begin
        case (st_r)
          ADCSQ_IDLE:
          begin
            if (start_i)
            begin
              st_r  <= ADCSQ_DELAY; // R15
              cnt_r <= dly_w - 8'h01;
            end
          end
          ADCSQ_DELAY:
          begin
            cnt_r <= cnt_r - 8'h01;
            if (last_w)
            begin
              st_r     <= ADCSQ_SAMPLE; // R15
              cnt_r    <= spl_w - 8'h01;
              sample_o <= 1'b1;
            end
          end
          ADCSQ_SAMPLE:
          begin
            cnt_r <= cnt_r - 8'h01;
            if (last_w)
            begin
              st_r     <= ADCSQ_CONV;
              cnt_r    <= cnv_w - 8'h01;
              stp_r    <= step_w - 8'h01;
              idx_r    <= 4'd9;
              sample_o <= 1'b0;
              dac_o    <= 10'h200;
            end
          end
          ADCSQ_CONV:
          begin
            cnt_r <= cnt_r - 8'h01;
            stp_r <= bit_w ? step_w - 8'h01 : stp_r - 8'h01;
            if (bit_w)
            begin
              dac_o[idx_r] <= cmp_i; // R5
              if (idx_r != 4'h0)
                dac_o[idx_r - 4'h1] <= 1'b1;
              idx_r <= idx_r - 4'h1;
            end
            if (last_w)
            begin
              done_o   <= 1'b1;
              result_o <= bit_w ? {dac_o[ADCSQ_RES_W-1:1], cmp_i} : dac_o;
              st_r     <= start_i ? ADCSQ_DELAY : ADCSQ_IDLE;
              cnt_r    <= dly_w - 8'h01;
            end
          end
          default:
            st_r <= ADCSQ_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** core/adcsq_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsq_top
  import adcsq_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  // Avalon-MM slave
  input  wire logic [7:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [3:0]             avs_byteenable_i,
  input  wire logic [31:0]            avs_writedata_i,
  output logic [31:0]                 avs_readdata_o,
  output logic                        avs_waitrequest_o,
  // External trigger and power state
  input  wire logic                   ext_trigger_pin_i,
  input  wire logic                   standby_i,
  // Analog front end
  input  wire logic                   cmp_i,
  output logic                        sample_o,
  output logic [ADCSQ_RES_W-1:0]      dac_o,
  output logic [2:0]                  chan_o,
  // Interrupt request
  output logic                        conv_end_irq_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic                    conv_end_flag_r;
  logic                    conv_end_flag_nxt;
  logic                    conv_end_irq_enable_r;
  logic                    conv_start_bit_r;
  logic                    conv_start_bit_nxt;
  logic                    scan_r;
  logic                    conv_speed_select_r;
  logic [2:0]              chsel_r;
  logic                    ext_trigger_enable_r;
  logic                    trg_bit0_r;
  logic                    trigger_edge_select_r;
  logic                    armed_r;
  logic                    armed_nxt;
  logic [2:0]              cur_r;
  logic [2:0]              cur_nxt;
  logic [1:0]              phase_r;
  logic [ADCSQ_RES_W-1:0]  data_r [0:7];
  logic                    trig_fire;
  logic                    done;
  logic [ADCSQ_RES_W-1:0]  result;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire       req_w     = avs_read_i | avs_write_i;
  wire       take_w    = req_w & ~avs_waitrequest_o;
  wire       wr_w      = take_w & avs_write_i & avs_byteenable_i[0];
  wire       rd_w      = take_w & avs_read_i;
  wire       sel_csr_w = (avs_address_i == ADCSQ_CSR_OFS);
  wire       sel_trg_w = (avs_address_i == ADCSQ_TRG_OFS);
  wire       sel_edg_w = (avs_address_i == ADCSQ_EDGE_OFS);
  wire       sel_dat_w = (avs_address_i[7:5] == ADCSQ_DATA_OFS[7:5])
                         && (avs_address_i[1:0] == 2'b00);
  wire [2:0] dat_idx_w = avs_address_i[4:2];
  wire       csr_wr_w  = wr_w & sel_csr_w;
  wire [7:0] wd_w      = avs_writedata_i[7:0];

  wire [7:0] csr_rd_w = {conv_end_flag_r, conv_end_irq_enable_r, conv_start_bit_r,
                         scan_r, conv_speed_select_r, chsel_r};
  wire [7:0] trg_rd_w = {ext_trigger_enable_r, ADCSQ_TRG_RSVD, trg_bit0_r}; // R3

  wire [31:0] rd_mux_w = sel_csr_w ? {24'h000000, csr_rd_w}
                       : sel_trg_w ? {24'h000000, trg_rd_w}
                       : sel_edg_w ? {31'h00000000, trigger_edge_select_r}
                       : sel_dat_w ? {22'h000000, data_r[dat_idx_w]}
                       : 32'h00000000;

  // ---------------------------------------------------------------
  // Channel group
  // ---------------------------------------------------------------
  wire [2:0] base_w  = {chsel_r[2], 2'b00}; // R11
  wire       last_ch_w = scan_r ? (cur_r == chsel_r) : 1'b1;

  // ---------------------------------------------------------------
  // Start control
  // ---------------------------------------------------------------
  wire sw_set_w    = csr_wr_w & wd_w[ADCSQ_CONV_START_BIT_BIT];
  wire sw_clr_w    = csr_wr_w & ~wd_w[ADCSQ_CONV_START_BIT_BIT];
  wire set_start_w = sw_set_w | trig_fire; // R1 R19
  wire new_start_w = set_start_w & ~conv_start_bit_r;
  wire stop_w      = standby_i | (sw_clr_w & ~trig_fire); // R21 R14
  wire round_end_w = done & last_ch_w;
  wire single_end_w = done & ~scan_r;
  wire restart_w   = scan_r & conv_start_bit_r & ~stop_w; // R13 R14
  wire abort_w     = stop_w & ~new_start_w;

  always_comb
  begin
    conv_start_bit_nxt = conv_start_bit_r;
    if (single_end_w)
      conv_start_bit_nxt = 1'b0; // R10
    if (set_start_w)
      conv_start_bit_nxt = 1'b1; // R1 R7
    if (stop_w)
      conv_start_bit_nxt = 1'b0; // R21
  end

  // ---------------------------------------------------------------
  // Conversion-end flag
  // ---------------------------------------------------------------
  wire flag_set_w = round_end_w & conv_start_bit_r;
  wire flag_clr_w = csr_wr_w & ~wd_w[ADCSQ_ADF_BIT] & armed_r; // R20

  always_comb
  begin
    conv_end_flag_nxt = conv_end_flag_r;
    if (flag_clr_w)
      conv_end_flag_nxt = 1'b0;
    if (flag_set_w)
      conv_end_flag_nxt = 1'b1; // R9 R13
  end

  always_comb
  begin
    armed_nxt = armed_r;
    if (csr_wr_w)
      armed_nxt = 1'b0;
    if (rd_w & sel_csr_w & avs_readdata_o[ADCSQ_ADF_BIT])
      armed_nxt = 1'b1; // R20
    if (flag_clr_w | ~conv_end_flag_r)
      armed_nxt = armed_nxt & conv_end_flag_nxt & ~flag_clr_w;
  end

  // ---------------------------------------------------------------
  // Channel sequencing
  // ---------------------------------------------------------------
  wire       scan_nxt_w  = csr_wr_w ? wd_w[ADCSQ_SCAN_BIT] : scan_r;
  wire [2:0] chsel_nxt_w = csr_wr_w ? wd_w[2:0] : chsel_r;
  wire [2:0] base_nxt_w  = {chsel_nxt_w[2], 2'b00};
  wire       cks_nxt_w   = csr_wr_w ? wd_w[ADCSQ_CKS_BIT] : conv_speed_select_r;

  always_comb
  begin
    cur_nxt = cur_r;
    if (new_start_w)
      cur_nxt = scan_nxt_w ? base_nxt_w : chsel_nxt_w; // R8 R11 R7
    else if (done & scan_r)
      cur_nxt = last_ch_w ? base_w : cur_r + 3'h1; // R12 R13
  end

  // ---------------------------------------------------------------
  // Start-write phase divider
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      phase_r <= 2'b00;
    else
      phase_r <= phase_r + 2'b01; // R16 R17
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      conv_end_flag_r       <= 1'b0;
      conv_end_irq_enable_r <= 1'b0;
      conv_start_bit_r      <= 1'b0;
      scan_r                <= 1'b0;
      conv_speed_select_r   <= 1'b0;
      chsel_r               <= 3'h0;
      armed_r               <= 1'b0;
      cur_r                 <= 3'h0;
    end
    else
    begin
      conv_end_flag_r  <= conv_end_flag_nxt;
      conv_start_bit_r <= conv_start_bit_nxt;
      armed_r          <= armed_nxt;
      cur_r            <= cur_nxt;
      if (csr_wr_w)
      begin
        conv_end_irq_enable_r <= wd_w[ADCSQ_CONV_END_IRQ_ENABLE_BIT];
        scan_r                <= wd_w[ADCSQ_SCAN_BIT];
        conv_speed_select_r   <= wd_w[ADCSQ_CKS_BIT];
        chsel_r               <= wd_w[2:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ext_trigger_enable_r  <= 1'b0;
      trg_bit0_r            <= 1'b0; // R4
      trigger_edge_select_r <= 1'b0;
    end
    else if (wr_w & sel_trg_w)
    begin
      ext_trigger_enable_r <= wd_w[ADCSQ_EXT_TRIGGER_ENABLE_BIT];
      trg_bit0_r           <= wd_w[0];
    end
    else if (wr_w & sel_edg_w)
      trigger_edge_select_r <= wd_w[0]; // R2
  end

  // ---------------------------------------------------------------
  // Result registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < 8; i++)
        data_r[i] <= '0;
    end
    else if (done & conv_start_bit_r)
      data_r[cur_r] <= result; // R8 R12
  end

  // ---------------------------------------------------------------
  // Bus answer: one wait state per access
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest_o <= ~(req_w & avs_waitrequest_o);
      if (req_w & avs_waitrequest_o)
        avs_readdata_o <= rd_mux_w;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt and channel outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      conv_end_irq_o <= 1'b0;
      chan_o         <= 3'h0;
    end
    else
    begin
      conv_end_irq_o <= conv_end_flag_r & conv_end_irq_enable_r; // R22 R9
      chan_o         <= cur_r;
    end
  end

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  adcsq_edge u_edge (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (ext_trigger_pin_i),
    .enable_i  (ext_trigger_enable_r),
    .rising_i  (trigger_edge_select_r),
    .fire_o    (trig_fire)
  );

  adcsq_conv u_conv (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .start_i   (new_start_w | restart_w), // R15 R19
    .abort_i   (abort_w),
    .first_i   (new_start_w), // R18
    .cks_i     (new_start_w ? cks_nxt_w : conv_speed_select_r),
    .phase_i   (phase_r),
    .cmp_i     (cmp_i),
    .sample_o  (sample_o),
    .dac_o     (dac_o),
    .done_o    (done),
    .result_o  (result)
  );

endmodule
`default_nettype wire

// *** sim/adcsq_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_asserts
  import adcsq_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  // Bus
  input  wire logic [7:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_readdata_o,
  input  wire logic                   avs_waitrequest_o,
  // Power state, analog side and interrupt request
  input  wire logic                   standby_i,
  input  wire logic                   sample_o,
  input  wire logic [ADCSQ_RES_W-1:0] dac_o,
  input  wire logic                   conv_end_irq_o
);
  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  logic [7:0] spl_cnt_r;
  logic [7:0] gap_cnt_r;
  logic       samp_q_r;
  logic       stby_r;
  logic       csr_take;
  logic       rd_take;
  assign csr_take = avs_write_i & ~avs_waitrequest_o & (avs_address_i == ADCSQ_CSR_OFS);
  assign rd_take  = avs_read_i & ~avs_waitrequest_o;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      spl_cnt_r <= 8'h00;
      gap_cnt_r <= 8'hFF;
      samp_q_r  <= 1'b0;
      stby_r    <= 1'b0;
    end
    else
    begin
      samp_q_r  <= sample_o;
      spl_cnt_r <= sample_o ? spl_cnt_r + 8'h01 : 8'h00;
      gap_cnt_r <= (sample_o && !samp_q_r) ? 8'h01 : gap_cnt_r + {7'h00, gap_cnt_r != 8'hFF};
      stby_r    <= standby_i | (stby_r & ~(sample_o & ~samp_q_r));
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_spl_len : assert property (
    $fell(sample_o) && !stby_r |-> spl_cnt_r == ADCSQ_SPL0 || spl_cnt_r == ADCSQ_SPL1)
    else $error("bad sample length");
  chk_conv_gap : assert property (
    $rose(sample_o) |-> gap_cnt_r >= 8'h42)
    else $error("conversions too close");
  chk_irq_drop : assert property (
    $fell(conv_end_irq_o) |-> $past(csr_take) || $past(csr_take, 2))
    else $error("irq fell without write");
  chk_standby_stop : assert property (
    $rose(standby_i) |-> ##2 (!sample_o) [*8])
    else $error("sampling in standby");
  chk_dac_hold : assert property (
    sample_o && $past(sample_o) |-> $stable(dac_o))
    else $error("dac moved in sampling");
  chk_trg_rsvd : assert property (
    rd_take && avs_address_i == ADCSQ_TRG_OFS |-> avs_readdata_o[6:1] == ADCSQ_TRG_RSVD)
    else $error("reserved bits not one");
  chk_start_busy : assert property (
    rd_take && avs_address_i == ADCSQ_CSR_OFS && sample_o && !stby_r
    |-> avs_readdata_o[ADCSQ_CONV_START_BIT_BIT])
    else $error("start low while busy");
  chk_irq_flag : assert property (
    rd_take && avs_address_i == ADCSQ_CSR_OFS && avs_readdata_o[7] && avs_readdata_o[6]
    |-> ##[0:1] conv_end_irq_o)
    else $error("irq missing");
endmodule

bind adcsq_top adcsq_top_asserts i_adcsq_top_asserts (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .standby_i(standby_i), .sample_o(sample_o),
  .dac_o(dac_o), .conv_end_irq_o(conv_end_irq_o));
`default_nettype wire

// *** sim/adcsq_afe_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsq_afe_model
  import adcsq_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  // Converter side
  input  wire logic                   sample_i,
  input  wire logic [ADCSQ_RES_W-1:0] dac_i,
  input  wire logic [2:0]             chan_i,
  output logic                        cmp_o
);
  logic [ADCSQ_RES_W-1:0] held_r;
  logic [ADCSQ_RES_W-1:0] level;
  assign level = 10'h0C3 + 10'(chan_i) * 10'h071;

  // Sample and hold of the selected input
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      held_r <= 10'h000;
    else if (sample_i)
      held_r <= level;
  end

  assign cmp_o = (held_r >= dac_i);
endmodule
`default_nettype wire

// *** sim/adcsq_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsq_bench
  import adcsq_pkg::*;
;
  typedef struct packed {logic conv_speed_select; logic [2:0] ch; logic [7:0] tmin; logic [7:0] tmax;} adcsq_row_t;
  adcsq_row_t rows [4] = '{'{1'b0, 3'h0, 8'h83, 8'h86}, '{1'b1, 3'h5, 8'h45, 8'h46},
                           '{1'b0, 3'h3, 8'h83, 8'h86}, '{1'b1, 3'h7, 8'h45, 8'h46}};
  logic             sys_clk_i;
  logic             rstn_i;
  logic [7:0]       avs_address_i;
  logic             avs_read_i;
  logic             avs_write_i;
  logic [31:0]      avs_writedata_i;
  logic [31:0]      avs_readdata_o;
  logic             avs_waitrequest_o;
  logic             ext_trigger_pin_i;
  logic             standby_i;
  logic             cmp_i;
  logic             sample_o;
  logic [9:0]       dac_o;
  logic [2:0]       chan_o;
  logic             conv_end_irq_o;
  logic [31:0]      d;
  logic             samp_q, irq_q;
  logic [2:0]       fall_ch[$];
  int               rise_t[$];
  int               errors;
  int               checked;
  int               cyc;
  int               t_wr, t_irq, n;

  adcsq_top i_adcsq_top (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(4'hF),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ext_trigger_pin_i(ext_trigger_pin_i),
    .standby_i(standby_i), .cmp_i(cmp_i), .sample_o(sample_o), .dac_o(dac_o),
    .chan_o(chan_o), .conv_end_irq_o(conv_end_irq_o));
  adcsq_afe_model i_adcsq_afe_model (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .sample_i(sample_o), .dac_i(dac_o), .chan_i(chan_o), .cmp_o(cmp_i));

  // ---------------------------------------------------------------
  // Clock, monitor and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    cyc    <= cyc + 1;
    samp_q <= sample_o;
    irq_q  <= conv_end_irq_o;
    if (sample_o && !samp_q) rise_t.push_back(cyc);
    if (!sample_o && samp_q) fall_ch.push_back(chan_o);
    if (conv_end_irq_o && !irq_q) t_irq <= cyc;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] lvl(input logic [2:0] ch);
    return 32'(10'h0C3 + 10'(ch) * 10'h071);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h000000, wd};
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    do
      @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    t_wr = cyc;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (conv_end_irq_o !== 1'b1 && k < 400)
    begin
      @(posedge sys_clk_i);
      k++;
    end
    if (k >= 400) check(32'h0, 32'h1, "no completion");
    @(posedge sys_clk_i);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rstn_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    ext_trigger_pin_i = 1'b0;
    standby_i = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    bus(0, ADCSQ_CSR_OFS, 8'h00); check(d, 32'h0, "control reset");
    bus(0, ADCSQ_TRG_OFS, 8'h00); check(d, 32'h7E, "trigger reset");
    bus(0, 8'h10, 8'h00); check(d, 32'h0, "unmapped read");
    foreach (rows[i])
    begin
      bus(1, ADCSQ_CSR_OFS, {4'h6, rows[i].conv_speed_select, rows[i].ch});
      n = t_wr + 3;
      wait_irq();
      check(32'(t_irq - n >= rows[i].tmin && t_irq - n <= rows[i].tmax), 32'h1, "time");
      bus(0, 8'(ADCSQ_DATA_OFS + {rows[i].ch, 2'b00}), 8'h00);
      check(d, lvl(rows[i].ch), "single result");
      bus(0, ADCSQ_CSR_OFS, 8'h00); check(d, {24'h0, 4'hC, rows[i].conv_speed_select, rows[i].ch}, "done");
      bus(1, ADCSQ_CSR_OFS, 8'h40);
      bus(0, ADCSQ_CSR_OFS, 8'h00); check(d, 32'h40, "flag clear");
      check(32'(conv_end_irq_o), 32'h0, "irq clear");
    end
    for (int e = 0; e < 2; e++)
    begin
      ext_trigger_pin_i <= e[0];
      bus(1, ADCSQ_EDGE_OFS, 8'(e));
      bus(1, ADCSQ_CSR_OFS, 8'h42);
      bus(1, ADCSQ_TRG_OFS, 8'h80);
      bus(0, ADCSQ_TRG_OFS, 8'h00); check(d, 32'hFE, "trigger readback");
      ext_trigger_pin_i <= ~e[0];
      repeat (6) @(posedge sys_clk_i);
      bus(0, ADCSQ_CSR_OFS, 8'h00); check(d, 32'h42, "wrong edge");
      ext_trigger_pin_i <= e[0];
      repeat (4) @(posedge sys_clk_i);
      bus(0, ADCSQ_CSR_OFS, 8'h00); check(d, 32'h62, "trigger start");
      wait_irq();
      bus(0, 8'(ADCSQ_DATA_OFS + 8'h08), 8'h00); check(d, lvl(3'h2), "trigger result");
      bus(1, ADCSQ_CSR_OFS, 8'h40);
      bus(0, ADCSQ_CSR_OFS, 8'h00); check(d, 32'hC0, "unarmed clear");
      bus(1, ADCSQ_CSR_OFS, 8'h40);
      bus(0, ADCSQ_CSR_OFS, 8'h00); check(d, 32'h40, "armed clear");
      bus(1, ADCSQ_TRG_OFS, 8'h00);
      ext_trigger_pin_i <= ~e[0];
      repeat (3) @(posedge sys_clk_i);
      ext_trigger_pin_i <= e[0];
      repeat (4) @(posedge sys_clk_i);
      bus(0, ADCSQ_CSR_OFS, 8'h00); check(d, 32'h40, "trigger disabled");
    end
    rise_t.delete();
    fall_ch.delete();
    bus(1, ADCSQ_CSR_OFS, 8'h7E);
    n = 0;
    while (fall_ch.size() < 4 && n < 1000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    for (int k = 0; k < 4; k++)
      check(32'(fall_ch[k]), (k == 3) ? 32'h4 : 32'(4 + k), "scan order");
    for (int k = 1; k < 4; k++)
      check(32'(rise_t[k] - rise_t[k-1]), 32'h42, "scan spacing");
    for (int k = 0; k < 3; k++)
    begin
      bus(0, 8'(ADCSQ_DATA_OFS + 8'h10 + 8'(4 * k)), 8'h00);
      check(d, lvl(3'(4 + k)), "scan result");
    end
    bus(0, ADCSQ_CSR_OFS, 8'h00); check(d, 32'hFE, "scan round");
    standby_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    standby_i <= 1'b0;
    bus(0, ADCSQ_CSR_OFS, 8'h00); check(32'(d[5]), 32'h0, "standby stop");
    n = rise_t.size();
    repeat (200) @(posedge sys_clk_i);
    check(32'(rise_t.size()), 32'(n), "stopped");
    finish_test();
  end
endmodule
`default_nettype wire
